// >>> tcm_defs.svh
// constants for the translation cache preload and mmu register move logic
// assumes inclusion by bare name from the package and the core module
`ifndef TCM_DEFS_SVH
`define TCM_DEFS_SVH
// axi4-lite register byte offsets
`define TCM_OFF_CTRL 12'h000
`define TCM_OFF_STATUS 12'h004
`define TCM_OFF_TC 12'h008
`define TCM_OFF_MMUSR 12'h00C
// ctrl register fields and reset value
`define TCM_CTRL_EN_BIT 0
`define TCM_CTRL_FLUSH_BIT 1
`define TCM_CTRL_RST 1'b1
// translation control register fields
`define TCM_TC_E_BIT 31
`define TCM_TC_PS_LSB 20
`define TCM_TC_IS_LSB 16
`define TCM_TC_TIA_LSB 12
`define TCM_TC_TIB_LSB 8
`define TCM_TC_TIC_LSB 4
`define TCM_TC_TID_LSB 0
`define TCM_TC_MIN_PS 4'h8
`define TCM_TC_ADDR_BITS 6'h20
// transparent window enable bit, root descriptor type field
`define TCM_TT_E_BIT 15
`define TCM_RP_DT_LSB 32
// exception vectors
`define TCM_VEC_ILLEGAL 8'h39
`define TCM_VEC_CONFIG 8'h38
// command extension word groups and register selects
`define TCM_GRP_RPTC 3'h2
`define TCM_GRP_STATUS 3'h3
`define TCM_GRP_TT 3'h0
`define TCM_PREG_TC 3'h0
`define TCM_PREG_SRP 3'h2
`define TCM_PREG_CRP 3'h3
`define TCM_PREG_TT0 3'h2
`define TCM_PREG_TT1 3'h3
// function code selector forms
`define TCM_FC_SFC 5'h00
`define TCM_FC_DFC 5'h01
`define TCM_FC_DREG 2'h1
`define TCM_FC_IMM3 2'h2
// effective address modes
`define TCM_EA_IND 3'h2
`define TCM_EA_D16 3'h5
`define TCM_EA_IDX 3'h6
`define TCM_EA_ABS 3'h7
`define TCM_EA_ABS_W 3'h0
`define TCM_EA_ABS_L 3'h1
// page tag split of the logical address
`define TCM_PAGE_LSB 12
`endif

// >>> tcm_pkg.sv
// types shared by the translation cache preload and mmu register move logic
// assumes tcm_defs.svh is on the include path
package tcm_pkg;
	`include "tcm_defs.svh"
	// command word fields as decoded by the core
	typedef struct packed {
		logic preload; // 1 preload, 0 register move
		logic supv; // core is in supervisor state
		logic rw; // preload: 1 read 0 write; move: 1 reg to memory
		logic fd; // flush disable of the move
		logic [2:0] grp; // extension word group of the move
		logic [2:0] preg; // register select of the move
		logic [2:0] ea_mode;
		logic [2:0] ea_reg;
		logic [4:0] fc_sel; // function code selector
	} tcm_cmd_t;
	typedef enum logic [2:0] {EXC_NONE, EXC_PRIV, EXC_ILLEGAL, EXC_CONFIG, EXC_BAD_EA} tcm_exc_t;
	typedef enum logic [1:0] {SZ_WORD, SZ_LONG, SZ_QUAD} tcm_size_t;
	typedef struct packed {
		tcm_exc_t exc;
		logic [7:0] vector;
		tcm_size_t size;
		logic [63:0] rdata;
	} tcm_rsp_t;
	typedef struct packed {
		logic [31:0] addr;
		logic [3:0] fc;
		logic set_mod; // set modified as well as used
	} tcm_walk_t;
	typedef enum logic [2:0] {PR_TC, PR_SRP, PR_CRP, PR_TT0, PR_TT1, PR_SR, PR_NONE} tcm_preg_t;
	typedef enum {ST_IDLE, ST_WALK, ST_FLUSH, ST_LOAD, ST_RESP} tcm_state_t;
endpackage

// >>> tcm_core.sv
// translation cache preload and mmu register move command logic
// assumes commands from a core in lockstep with clk, a table walker that sets
// used/modified bits, and an axi4-lite master for status and control
`timescale 1ns/100ps
`include "tcm_defs.svh"
////////////////////////////////////////////////////////////////////////////////
module tcm_core import tcm_pkg::*; #(
	parameter bit COPROC = 1'b1,
	parameter int DEPTH = 8
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// axi4-lite slave
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// command from the core
	input wire logic cmd_valid,
	input wire tcm_cmd_t cmd,
	input wire logic [31:0] cmd_ea,
	input wire logic [63:0] cmd_wdata,
	input wire logic [7:0][31:0] core_dregs,
	input wire logic [2:0] core_sfc,
	input wire logic [2:0] core_dfc,
	output logic cmd_ready,
	// response to the core
	output logic rsp_valid,
	output tcm_rsp_t rsp,
	// table walker
	output logic walk_req,
	output tcm_walk_t walk,
	input wire logic walk_done,
	input wire logic walk_found,
	input wire logic [19:0] walk_ppage,
	// system inputs
	input wire logic lbus_arb,
	input wire logic translation_disable_input
);
	localparam int IW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	////////////////////////////////////////////////////////////////////////////
	// state and storage
	tcm_state_t state_r; // command sequencer
	logic cmd_ready_r, rsp_valid_r, walk_req_r; // output flops
	tcm_rsp_t rsp_r;
	tcm_walk_t walk_r;
	logic found_r; // walk result
	logic [19:0] ppage_r;
	logic [31:0] tc_r, tt0_r, tt1_r; // mmu registers
	logic [63:0] srp_r, crp_r;
	logic [15:0] mmusr_r;
	logic [DEPTH-1:0] valid_r; // translation cache
	logic [3:0] fc_a [DEPTH];
	logic [19:0] page_a [DEPTH];
	logic [19:0] ppage_a [DEPTH];
	logic [DEPTH-1:0] flt_a;
	logic [IW-1:0] rr_r; // replacement pointer
	logic hit_r; // preload found an old entry
	logic ctrl_en_r, ctrl_flush_r; // software control
	tcm_exc_t last_exc_r;
	logic xdis_r; // sampled disable input, status only
	logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
	logic [1:0] bresp_r, rresp_r;
	logic [31:0] rdata_r;
	// decode results
	logic acc, fc_bad, ea_bad, tc_ok, rp_ok, mv_wr, mv_flush;
	logic [3:0] fc_val;
	tcm_preg_t tgt;
	tcm_exc_t dec_exc;
	logic [7:0] dec_vec;
	logic [5:0] tc_sum;
	////////////////////////////////////////////////////////////////////////////
	// command decode
	always_comb begin
		acc = cmd_valid && cmd_ready_r;
		fc_val = 4'h0;
		fc_bad = 1'b0;
		// function code source
		if (COPROC) begin
			if (cmd.fc_sel[4]) begin
				fc_val = cmd.fc_sel[3:0];
			end else if (cmd.fc_sel[4:3] == `TCM_FC_DREG) begin
				fc_val = core_dregs[cmd.fc_sel[2:0]][3:0];
			end else if (cmd.fc_sel == `TCM_FC_SFC) begin
				fc_val = {1'b0, core_sfc};
			end else if (cmd.fc_sel == `TCM_FC_DFC) begin
				fc_val = {1'b0, core_dfc};
			end else begin
				fc_bad = 1'b1;
			end
		end else begin
			if (cmd.fc_sel[4:3] == `TCM_FC_IMM3) begin
				fc_val = {1'b0, cmd.fc_sel[2:0]};
			end else if (cmd.fc_sel[4:3] == `TCM_FC_DREG) begin
				fc_val = {1'b0, core_dregs[cmd.fc_sel[2:0]][2:0]};
			end else if (cmd.fc_sel == `TCM_FC_SFC) begin
				fc_val = {1'b0, core_sfc};
			end else if (cmd.fc_sel == `TCM_FC_DFC) begin
				fc_val = {1'b0, core_dfc};
			end else begin
				fc_bad = 1'b1;
			end
		end
		// control alterable modes only
		ea_bad = !(cmd.ea_mode == `TCM_EA_IND || cmd.ea_mode == `TCM_EA_D16 ||
			cmd.ea_mode == `TCM_EA_IDX || (cmd.ea_mode == `TCM_EA_ABS &&
			(cmd.ea_reg == `TCM_EA_ABS_W || cmd.ea_reg == `TCM_EA_ABS_L)));
		// move target
		tgt = PR_NONE;
		if (cmd.grp == `TCM_GRP_RPTC) begin
			if (cmd.preg == `TCM_PREG_TC) tgt = PR_TC;
			if (cmd.preg == `TCM_PREG_SRP) tgt = PR_SRP;
			if (cmd.preg == `TCM_PREG_CRP) tgt = PR_CRP;
		end else if (cmd.grp == `TCM_GRP_TT) begin
			if (cmd.preg == `TCM_PREG_TT0) tgt = PR_TT0;
			if (cmd.preg == `TCM_PREG_TT1) tgt = PR_TT1;
		end else if (cmd.grp == `TCM_GRP_STATUS && cmd.preg == 3'h0) begin
			tgt = PR_SR;
		end
		// consistency of an enabled tc: page size floor, fields cover the address
		tc_sum = 6'(cmd_wdata[`TCM_TC_PS_LSB +: 4]) + 6'(cmd_wdata[`TCM_TC_IS_LSB +: 4]) +
			6'(cmd_wdata[`TCM_TC_TIA_LSB +: 4]) + 6'(cmd_wdata[`TCM_TC_TIB_LSB +: 4]) +
			6'(cmd_wdata[`TCM_TC_TIC_LSB +: 4]) + 6'(cmd_wdata[`TCM_TC_TID_LSB +: 4]);
		tc_ok = !cmd_wdata[`TCM_TC_E_BIT] || (tc_sum == `TCM_TC_ADDR_BITS &&
			cmd_wdata[`TCM_TC_PS_LSB +: 4] >= `TCM_TC_MIN_PS);
		rp_ok = cmd_wdata[`TCM_RP_DT_LSB +: 2] != 2'h0;
		// exception priority: privilege, address mode, operation
		dec_exc = EXC_NONE;
		dec_vec = 8'h00;
		if (!cmd.supv) begin
			dec_exc = EXC_PRIV;
		end else if (ea_bad) begin
			dec_exc = EXC_BAD_EA;
		end else if (cmd.preload && (fc_bad || (COPROC && !tc_r[`TCM_TC_E_BIT]))) begin
			dec_exc = EXC_ILLEGAL;
			dec_vec = `TCM_VEC_ILLEGAL;
		end else if (!cmd.preload && tgt == PR_NONE) begin
			dec_exc = EXC_ILLEGAL;
		end
		mv_wr = acc && !cmd.preload && dec_exc == EXC_NONE && !cmd.rw;
		mv_flush = mv_wr && !cmd.fd && tgt != PR_SR;
	end
	////////////////////////////////////////////////////////////////////////////
	// preload sequencer: walk, flush old entry, load new entry, answer
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_r <= ST_IDLE;
		end else begin
			unique case (state_r)
				ST_IDLE: begin
					if (acc && cmd.preload && dec_exc == EXC_NONE) state_r <= ST_WALK;
				end
				ST_WALK: begin
					if (walk_req_r && walk_done) state_r <= ST_FLUSH;
				end
				ST_FLUSH: begin
					state_r <= ST_LOAD;
				end
				ST_LOAD: begin
					state_r <= ST_RESP;
				end
				ST_RESP: begin
					state_r <= ST_IDLE;
				end
			endcase
		end
	end
	// walker request, held until done; not started while another master arbitrates
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			walk_req_r <= 1'b0;
			walk_r <= '0;
			found_r <= 1'b0;
			ppage_r <= 20'h0_0000;
		end else begin
			if (state_r == ST_IDLE && acc) begin
				walk_r <= '{addr: cmd_ea, fc: fc_val, set_mod: !cmd.rw};
			end
			if (state_r == ST_WALK && !walk_req_r && !lbus_arb) begin
				walk_req_r <= 1'b1;
			end else if (walk_req_r && walk_done) begin
				walk_req_r <= 1'b0;
				found_r <= walk_found;
				ppage_r <= walk_ppage;
			end
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// translation cache control state
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			valid_r <= '0;
			rr_r <= '0;
			hit_r <= 1'b0;
		end else if (mv_flush || ctrl_flush_r) begin
			valid_r <= '0;
		end else if (state_r == ST_FLUSH) begin
			hit_r <= 1'b0;
			for (int i = 0; i < DEPTH; i++) begin
				// coprocessor drops the old entry only when the walk found a translation
				if ((found_r || !COPROC) && valid_r[i] && fc_a[i] == walk_r.fc &&
					page_a[i] == walk_r.addr[31:`TCM_PAGE_LSB]) begin
					valid_r[i] <= 1'b0;
					hit_r <= 1'b1;
				end
			end
		end else if (state_r == ST_LOAD && (found_r || !COPROC)) begin
			valid_r[rr_r] <= 1'b1;
			rr_r <= (rr_r == IW'(DEPTH - 1)) ? '0 : rr_r + 1'b1;
		end
	end
	// entry payload; integrated unit records a failed walk as a faulted entry
	always_ff @(posedge clk) begin
		if (state_r == ST_LOAD) begin
			fc_a[rr_r] <= walk_r.fc;
			page_a[rr_r] <= walk_r.addr[31:`TCM_PAGE_LSB];
			ppage_a[rr_r] <= ppage_r;
			flt_a[rr_r] <= !found_r;
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// mmu registers written by the move
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			tc_r <= 32'h0000_0000;
			srp_r <= 64'h0000_0000_0000_0000;
			crp_r <= 64'h0000_0000_0000_0000;
			tt0_r <= 32'h0000_0000;
			tt1_r <= 32'h0000_0000;
			mmusr_r <= 16'h0000;
		end else if (mv_wr) begin
			unique case (tgt)
				PR_SRP: srp_r <= cmd_wdata;
				PR_CRP: crp_r <= cmd_wdata;
				PR_TC: begin
					// passing checks leave the operand with enable cleared
					if (cmd_wdata[`TCM_TC_E_BIT] && tc_ok) begin
						tc_r <= {1'b0, cmd_wdata[30:0]};
					end else begin
						tc_r <= cmd_wdata[31:0];
					end
				end
				PR_TT0: tt0_r <= cmd_wdata[31:0];
				PR_TT1: tt1_r <= cmd_wdata[31:0];
				PR_SR: mmusr_r <= cmd_wdata[15:0];
				default: begin
				end
			endcase
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// command handshake and response
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cmd_ready_r <= 1'b0;
			rsp_valid_r <= 1'b0;
			rsp_r <= '{exc: EXC_NONE, vector: 8'h00, size: SZ_WORD, rdata: '0};
			last_exc_r <= EXC_NONE;
			xdis_r <= 1'b0;
		end else begin
			xdis_r <= translation_disable_input;
			cmd_ready_r <= ctrl_en_r && !acc && (state_r == ST_IDLE || state_r == ST_RESP);
			rsp_valid_r <= 1'b0;
			if (acc && (dec_exc != EXC_NONE || !cmd.preload)) begin
				rsp_valid_r <= 1'b1;
				rsp_r <= '{exc: dec_exc, vector: dec_vec, size: SZ_LONG, rdata: '0};
				last_exc_r <= dec_exc;
				if (dec_exc == EXC_NONE) begin
					unique case (tgt)
						PR_SRP: rsp_r.rdata <= srp_r;
						PR_CRP: rsp_r.rdata <= crp_r;
						PR_TC: rsp_r.rdata <= {32'h0000_0000, tc_r};
						PR_TT0: rsp_r.rdata <= {32'h0000_0000, tt0_r};
						PR_TT1: rsp_r.rdata <= {32'h0000_0000, tt1_r};
						PR_SR: rsp_r.rdata <= {48'h0000_0000_0000, mmusr_r};
						default: rsp_r.rdata <= '0;
					endcase
					if (tgt == PR_SRP || tgt == PR_CRP) rsp_r.size <= SZ_QUAD;
					if (tgt == PR_SR) rsp_r.size <= SZ_WORD;
					// register is stored first; the error follows in the answer
					if (!cmd.rw && (((tgt == PR_SRP || tgt == PR_CRP) && !rp_ok) ||
						(tgt == PR_TC && !tc_ok))) begin
						rsp_r.exc <= EXC_CONFIG;
						rsp_r.vector <= `TCM_VEC_CONFIG;
						last_exc_r <= EXC_CONFIG;
					end
				end
			end else if (state_r == ST_LOAD) begin
				rsp_valid_r <= 1'b1;
				rsp_r <= '{exc: EXC_NONE, vector: 8'h00, size: SZ_WORD, rdata: '0};
				last_exc_r <= EXC_NONE;
			end
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// axi4-lite write channel: address and data taken together
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			awready_r <= 1'b0;
			wready_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= 2'h0;
			ctrl_en_r <= `TCM_CTRL_RST;
			ctrl_flush_r <= 1'b0;
		end else begin
			ctrl_flush_r <= 1'b0;
			awready_r <= !awready_r && s_axi_awvalid && s_axi_wvalid && !bvalid_r;
			wready_r <= !awready_r && s_axi_awvalid && s_axi_wvalid && !bvalid_r;
			if (awready_r && s_axi_awvalid && s_axi_wvalid) begin
				bvalid_r <= 1'b1;
				bresp_r <= 2'h0;
				if (s_axi_awaddr == `TCM_OFF_CTRL) begin
					if (s_axi_wstrb[0]) begin
						ctrl_en_r <= s_axi_wdata[`TCM_CTRL_EN_BIT];
						ctrl_flush_r <= s_axi_wdata[`TCM_CTRL_FLUSH_BIT];
					end
				end else if (s_axi_awaddr != `TCM_OFF_STATUS && s_axi_awaddr != `TCM_OFF_TC &&
					s_axi_awaddr != `TCM_OFF_MMUSR) begin
					bresp_r <= 2'h2; // unmapped
				end
			end else if (bvalid_r && s_axi_bready) begin
				bvalid_r <= 1'b0;
			end
		end
	end
	// axi4-lite read channel
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			arready_r <= 1'b0;
			rvalid_r <= 1'b0;
			rresp_r <= 2'h0;
			rdata_r <= 32'h0000_0000;
		end else begin
			arready_r <= !arready_r && s_axi_arvalid && !rvalid_r;
			if (arready_r && s_axi_arvalid) begin
				rvalid_r <= 1'b1;
				rresp_r <= 2'h0;
				unique case (s_axi_araddr)
					`TCM_OFF_CTRL: rdata_r <= {31'h0000_0000, ctrl_en_r};
					`TCM_OFF_STATUS: rdata_r <= {16'h0000, 8'($countones(valid_r)), 2'h0,
						xdis_r, hit_r, last_exc_r, state_r != ST_IDLE};
					`TCM_OFF_TC: rdata_r <= tc_r;
					`TCM_OFF_MMUSR: rdata_r <= {16'h0000, mmusr_r};
					default: begin
						rdata_r <= 32'h0000_0000;
						rresp_r <= 2'h2;
					end
				endcase
			end else if (rvalid_r && s_axi_rready) begin
				rvalid_r <= 1'b0;
			end
		end
	end
	// outputs straight from flops
	assign s_axi_awready = awready_r;
	assign s_axi_wready = wready_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rresp = rresp_r;
	assign s_axi_rdata = rdata_r;
	assign cmd_ready = cmd_ready_r;
	assign rsp_valid = rsp_valid_r;
	assign rsp = rsp_r;
	assign walk_req = walk_req_r;
	assign walk = walk_r;
	////////////////////////////////////////////////////////////////////////////
	// checks
	AST_PRIV_TRAP: assert property (@(posedge clk) disable iff (sys_rst)
		acc && !cmd.supv |=> rsp_valid_r && rsp_r.exc == EXC_PRIV && state_r == ST_IDLE)
		else $error("user command not trapped");
	AST_ILLEGAL_VEC: assert property (@(posedge clk) disable iff (sys_rst)
		acc && COPROC && cmd.preload && cmd.supv && !ea_bad && !tc_r[`TCM_TC_E_BIT]
		|=> rsp_r.exc == EXC_ILLEGAL && rsp_r.vector == 8'h39)
		else $error("preload with enable clear not illegal");
	AST_BAD_EA: assert property (@(posedge clk) disable iff (sys_rst)
		acc && cmd.supv && ea_bad |=> rsp_valid_r && rsp_r.exc == EXC_BAD_EA)
		else $error("bad address mode accepted");
	AST_WALK_KIND: assert property (@(posedge clk) disable iff (sys_rst)
		acc && cmd.preload && dec_exc == EXC_NONE
		|=> state_r == ST_WALK && walk_r.set_mod == !$past(cmd.rw) &&
		walk_r.addr == $past(cmd_ea))
		else $error("walk request kind wrong");
	AST_WALK_NO_ARB: assert property (@(posedge clk) disable iff (sys_rst)
		$rose(walk_req_r) |-> $past(!lbus_arb) && $past(state_r == ST_WALK))
		else $error("walk started during arbitration");
	AST_FINAL_PHASES: assert property (@(posedge clk) disable iff (sys_rst)
		state_r == ST_FLUSH |=> state_r == ST_LOAD ##1 state_r == ST_RESP && rsp_valid_r)
		else $error("final phases stalled");
	AST_MOVE_FLUSH: assert property (@(posedge clk) disable iff (sys_rst)
		mv_wr && !cmd.fd && tgt == PR_SRP |=> valid_r == '0 && srp_r == $past(cmd_wdata))
		else $error("root write did not store and flush");
	AST_NO_FLUSH: assert property (@(posedge clk) disable iff (sys_rst)
		mv_wr && cmd.fd && state_r == ST_IDLE && !ctrl_flush_r |=> valid_r == $past(valid_r))
		else $error("flush disable ignored");
	AST_TC_CLEAR_E: assert property (@(posedge clk) disable iff (sys_rst)
		mv_wr && tgt == PR_TC && cmd_wdata[31] && tc_ok
		|=> !tc_r[31] && tc_r[30:0] == $past(cmd_wdata[30:0]) && rsp_r.exc == EXC_NONE)
		else $error("checked tc kept enable");
	AST_RP_SIZE: assert property (@(posedge clk) disable iff (sys_rst)
		acc && !cmd.preload && dec_exc == EXC_NONE && tgt == PR_CRP |=> rsp_r.size == SZ_QUAD)
		else $error("root move not quad");
	COV_PRELOAD: cover property (@(posedge clk) disable iff (sys_rst)
		state_r == ST_LOAD && found_r ##1 rsp_valid_r);
	COV_CONFIG: cover property (@(posedge clk) disable iff (sys_rst)
		rsp_valid_r && rsp_r.exc == EXC_CONFIG);
	COV_HIT: cover property (@(posedge clk) disable iff (sys_rst) state_r == ST_LOAD && hit_r);
endmodule

// >>> tcm_walker.sv
// table walker model for the preload path: answers each walk after a delay
// assumes walk_req is held by the core until the edge that samples walk_done
`timescale 1ns/100ps
module tcm_walker import tcm_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// walk port
	input wire logic walk_req,
	input wire tcm_walk_t walk,
	input wire logic [3:0] delay,
	output logic walk_done,
	output logic walk_found,
	output logic [19:0] walk_ppage,
	// last request seen, for the bench to judge
	output tcm_walk_t last_walk
);
	logic [3:0] cnt_r; // cycles spent on the current walk
	////////////////////////////////////////////////////////////////////////////////
	// one done pulse per walk; result lines scramble outside it
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cnt_r <= 4'h0;
			walk_done <= 1'b0;
			walk_found <= 1'b0;
			walk_ppage <= 20'h0_0000;
			last_walk <= '0;
		end else if (walk_done || !walk_req) begin
			// no answer pending: lines carry no stale value
			cnt_r <= 4'h0;
			walk_done <= 1'b0;
			walk_found <= ~walk_found;
			walk_ppage <= ~walk_ppage;
		end else if (cnt_r == delay) begin
			walk_done <= 1'b1;
			walk_found <= 1'b1;
			walk_ppage <= walk.addr[31:12];
			last_walk <= walk;
		end else begin
			cnt_r <= cnt_r + 4'h1;
		end
	end
endmodule

// >>> tcm_core_tb.sv
// self-checking bench for the preload and register move logic
// assumes both variants, each with a walker model beside it
`timescale 1ns/100ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_errors++; \
	$display("[ERR] %0t got %h exp %h", $time, a, b); end end
module tcm_core_tb;
	import tcm_pkg::*;
	logic clk = 0, sys_rst = 1, cmd_valid = 0, cmd_ready, rsp_valid, walk_req, walk_done;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
	logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, walk_found, lbus_arb = 0, translation_disable_input = 0;
	logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, cmd_ea = 0, rd;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	logic [3:0] s_axi_wstrb = 4'hF, delay = 0;
	logic [63:0] cmd_wdata = 0;
	logic [7:0][31:0] core_dregs = '0;
	logic [2:0] core_sfc = 3'h5, core_dfc = 3'h2;
	logic [19:0] walk_ppage;
	tcm_cmd_t cmd = '0;
	tcm_rsp_t rsp;
	tcm_walk_t walk, last_walk;
	int n_errors = 0, n_tests = 0;
	// integrated variant: own command valid, answer and walker
	logic i_cmd_valid = 0, i_cmd_ready, i_rsp_valid, i_walk_req, i_done, i_found;
	logic [19:0] i_ppage;
	tcm_rsp_t i_rsp;
	tcm_walk_t i_walk, i_last;
	bit use_int = 0; // run offers the command to the integrated unit
	tcm_core dut_u (.clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cmd_valid, .cmd,
		.cmd_ea, .cmd_wdata, .core_dregs, .core_sfc, .core_dfc, .cmd_ready, .rsp_valid,
		.rsp, .walk_req, .walk, .walk_done, .walk_found, .walk_ppage, .lbus_arb,
		.translation_disable_input);
	tcm_walker walk_u (.clk, .sys_rst, .walk_req, .walk, .delay, .walk_done,
		.walk_found, .walk_ppage, .last_walk);
	tcm_core #(.COPROC(1'b0)) dut_int_u (.clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready(), .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready(),
		.s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready(), .s_axi_rdata(), .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready,
		.cmd_valid(i_cmd_valid), .cmd, .cmd_ea, .cmd_wdata, .core_dregs, .core_sfc,
		.core_dfc, .cmd_ready(i_cmd_ready), .rsp_valid(i_rsp_valid), .rsp(i_rsp),
		.walk_req(i_walk_req), .walk(i_walk), .walk_done(i_done), .walk_found(i_found),
		.walk_ppage(i_ppage), .lbus_arb, .translation_disable_input);
	tcm_walker walk_int_u (.clk, .sys_rst, .walk_req(i_walk_req), .walk(i_walk), .delay,
		.walk_done(i_done), .walk_found(i_found), .walk_ppage(i_ppage), .last_walk(i_last));
	initial begin
		forever #2.5 clk = ~clk;
	end
	// the other master arbitrates as each preload is taken by dut_u and right after each of its walks; it stays low while the integrated unit runs
	always @(posedge clk) begin
		lbus_arb <= walk_done || (cmd_valid && cmd_ready && cmd.preload);
	end
	task automatic tally_and_finish;
		if (n_errors == 0 && n_tests > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// one axi4-lite transfer; entered just after a rising edge
	task automatic axi(input bit wr, input logic [11:0] a, input logic [31:0] wd);
		int k;
		if (wr) begin
			s_axi_awaddr <= a; s_axi_wdata <= wd; s_axi_bready <= 1;
			s_axi_awvalid <= 1; s_axi_wvalid <= 1;
		end else begin
			s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
		end
		for (k = 0; k < 50; k++) begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
			if (s_axi_arready) s_axi_arvalid <= 0;
			if (wr ? s_axi_bvalid : s_axi_rvalid) break;
		end
		rd = s_axi_rdata; rs = wr ? s_axi_bresp : s_axi_rresp;
		s_axi_bready <= 0; s_axi_rready <= 0;
		// let an edge pass so the next transfer does not reassign the ready lines
		@(posedge clk);
		if (k == 50) begin n_errors++; tally_and_finish(); end
	endtask
	// one command to the core, waits for its response
	task automatic run(input tcm_cmd_t c, input logic [31:0] ea, input logic [63:0] wd);
		int k;
		cmd <= c; cmd_ea <= ea; cmd_wdata <= wd;
		if (use_int) i_cmd_valid <= 1; else cmd_valid <= 1;
		for (k = 0; k < 60; k++) begin
			@(posedge clk);
			if (cmd_valid && cmd_ready) cmd_valid <= 0;
			if (i_cmd_valid && i_cmd_ready) i_cmd_valid <= 0;
			if (use_int ? i_rsp_valid : rsp_valid) break;
		end
		if (k == 60) begin n_errors++; tally_and_finish(); end
	endtask
	function automatic tcm_cmd_t mv(logic rw, logic fd, logic [2:0] g, logic [2:0] p);
		return '{1'b0, 1'b1, rw, fd, g, p, 3'h2, 3'h0, 5'h00};
	endfunction
	function automatic tcm_cmd_t pl(logic s, logic rw, logic [2:0] m, logic [4:0] f);
		return '{1'b1, s, rw, 1'b0, 3'h0, 3'h0, m, 3'h1, f};
	endfunction
	////////////////////////////////////////////////////////////////////////////////
	// bus map, refusals and traps before translation is on
	task automatic t_basic;
		axi(0, 12'h000, 0); `CHK(rd, 32'h0000_0001)
		axi(0, 12'h010, 0); `CHK(rs, 2'h2)
		axi(1, 12'h010, 1); `CHK(rs, 2'h2)
		run(pl(0, 1, 3'h2, 5'h10), 32'h0000_1000, 0); `CHK(rsp.exc, EXC_PRIV)
		run(pl(1, 1, 3'h2, 5'h10), 32'h0000_1000, 0); `CHK(rsp.exc, EXC_ILLEGAL)
		`CHK(rsp.vector, 8'h39)
		run(pl(1, 1, 3'h0, 5'h10), 32'h0000_1000, 0); `CHK(rsp.exc, EXC_BAD_EA)
	endtask
	// control register moves: pass clears enable, fail stores then traps
	task automatic t_tc;
		run(mv(0, 0, 3'h2, 3'h0), 32'h0, 64'h8080_CC00); `CHK(rsp.exc, EXC_NONE)
		run(mv(1, 0, 3'h2, 3'h0), 32'h0, 0); `CHK(rsp.rdata[31:0], 32'h0080_CC00)
		`CHK(rsp.size, SZ_LONG)
		run(mv(0, 1, 3'h2, 3'h0), 32'h0, 64'h8000_0000); `CHK(rsp.exc, EXC_CONFIG)
		`CHK(rsp.vector, 8'h38)
		axi(0, 12'h008, 0); `CHK(rd, 32'h8000_0000)
	endtask
	// root pointers, window and status sizes
	task automatic t_regs;
		run(mv(0, 0, 3'h2, 3'h2), 32'h0, 64'h0000_0000_1234_5678); `CHK(rsp.exc, EXC_CONFIG)
		run(mv(1, 0, 3'h2, 3'h2), 32'h0, 0); `CHK(rsp.rdata, 64'h0000_0000_1234_5678)
		`CHK(rsp.size, SZ_QUAD)
		run(mv(0, 0, 3'h2, 3'h3), 32'h0, 64'h0000_0002_0000_0010); `CHK(rsp.exc, EXC_NONE)
		run(mv(0, 0, 3'h0, 3'h2), 32'h0, 64'h0000_8000); `CHK(rsp.exc, EXC_NONE)
		run(mv(1, 0, 3'h0, 3'h2), 32'h0, 0); `CHK(rsp.rdata[31:0], 32'h0000_8000)
		run(mv(1, 0, 3'h3, 3'h0), 32'h0, 0); `CHK(rsp.size, SZ_WORD)
	endtask
	// preloads across every selector form, direction and address mode except absolute short
	task automatic t_preload;
		logic [4:0] sel[4] = '{5'h1A, 5'h0B, 5'h00, 5'h01};
		logic [3:0] fc[4] = '{4'hA, 4'hE, 4'h5, 4'h2};
		logic [2:0] md[4] = '{3'h2, 3'h5, 3'h6, 3'h7};
		core_dregs[3] <= 32'hFFFF_FFFE;
		for (int i = 0; i < 4; i++) begin
			delay <= 4'(i * 3);
			run(pl(1, i[0], md[i], sel[i]), 32'h0004_2000 + i, 0);
			`CHK(rsp.exc, EXC_NONE)
			`CHK(last_walk.addr, 32'h0004_2000 + i)
			`CHK(last_walk.fc, fc[i])
			`CHK(last_walk.set_mod, ~i[0])
		end
		// same address again: old entry dropped, new one installed, four remain
		run(pl(1, 0, md[0], sel[0]), 32'h0004_2000, 0); `CHK(rsp.exc, EXC_NONE)
		axi(0, 12'h004, 0); `CHK(rd, 32'h0000_0410)
	endtask
	// disabling the block holds commands off
	task automatic t_ctrl;
		axi(1, 12'h000, 0); `CHK(rs, 2'h0)
		repeat (2) @(posedge clk);
		`CHK(cmd_ready, 1'b0)
		axi(1, 12'h000, 3);
		axi(0, 12'h004, 0); `CHK(rd[15:8], 8'h00)
	endtask
	// integrated unit: 3-bit selector, runs with enable clear and disable input set
	task automatic t_integ;
		use_int = 1;
		translation_disable_input <= 1;
		run(pl(1, 0, 3'h2, 5'h0B), 32'h0008_3000, 0); `CHK(i_rsp.exc, EXC_NONE)
		`CHK(i_last.fc, 4'h6)
		`CHK(i_last.addr, 32'h0008_3000)
		run(pl(1, 1, 3'h2, 5'h15), 32'h0008_4000, 0); `CHK(i_last.fc, 4'h5)
		`CHK(i_last.set_mod, 1'b0)
		run(pl(1, 1, 3'h2, 5'h19), 32'h0008_5000, 0); `CHK(i_rsp.exc, EXC_ILLEGAL)
		use_int = 0;
	endtask
	initial begin
		repeat (4) @(posedge clk);
		sys_rst <= 0;
		repeat (2) @(posedge clk);
		t_basic();
		t_tc();
		t_regs();
		t_preload();
		t_integ();
		t_ctrl();
		tally_and_finish();
	end
endmodule
